/* File: hw/dfrs_pkg.sv */
// Package of register offsets, field layouts, reset values and codes for the frequency selector
package dfrs_pkg;
  // Register byte offsets (all word aligned)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BIND = 8'h04;
  localparam logic [7:0] OFF_UL_OFS = 8'h08;
  localparam logic [7:0] OFF_AUX_RANGE = 8'h0C;
  localparam logic [7:0] OFF_SUP_OFS = 8'h10;
  localparam logic [7:0] OFF_PRESET = 8'h14;
  localparam logic [7:0] OFF_MAXF = 8'h18;
  localparam logic [7:0] OFF_UL_DIG = 8'h1C;
  localparam logic [7:0] OFF_CARRIER = 8'h20;
  localparam logic [7:0] OFF_MODEL = 8'h24;
  localparam logic [7:0] OFF_RESTORE = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2C;
  localparam logic [7:0] OFF_TARGET = 8'h30;
  localparam logic [7:0] OFF_KEYPAD = 8'h34;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ULSRC_LSB = 4;
  localparam int CTRL_FSRC_LSB = 8;
  localparam int CTRL_CARR_EN_BIT = 12;
  localparam int CTRL_UDBASE_BIT = 13;
  localparam int CTRL_RETAIN_BIT = 14;
  localparam logic [31:0] CTRL_RESET = 32'h0000_1000;
  // Frequencies in 0.01 Hz units, 16 bits
  localparam logic [15:0] PRESET_RESET = 16'h1388;
  localparam logic [15:0] MAXF_RESET = 16'h1388;
  localparam logic [15:0] UL_DIG_RESET = 16'h1388;
  localparam logic [15:0] OFS_RESET = 16'h0000;
  localparam logic [15:0] BIND_RESET = 16'h0000;
  localparam logic [7:0] AUX_RANGE_RESET = 8'h64;
  localparam logic [7:0] AUX_RANGE_MAX = 8'h96;
  localparam logic [7:0] CARRIER_RESET = 8'h3C;
  localparam logic [7:0] CARRIER_STEP = 8'h0A;
  localparam logic [7:0] CARRIER_MIN = 8'h05;
  localparam logic [15:0] UPDOWN_STEP = 16'h0001;
  // Restore commands
  localparam logic [1:0] RESTORE_NONE = 2'h0;
  localparam logic [1:0] RESTORE_DEFAULTS = 2'h1;
  localparam logic [1:0] RESTORE_CLR_FAULT = 2'h2;
  // Bound frequency source codes (binding digits)
  localparam logic [3:0] FS_NONE = 4'h0;
  localparam logic [3:0] FS_KEYPAD = 4'h1;
  localparam logic [3:0] FS_AI1 = 4'h2;
  localparam logic [3:0] FS_AI2 = 4'h3;
  localparam logic [3:0] FS_AI3 = 4'h4;
  localparam logic [3:0] FS_PULSE = 4'h5;
  localparam logic [3:0] FS_MULTI = 4'h6;
  localparam logic [3:0] FS_PLC = 4'h7;
  localparam logic [3:0] FS_PID = 4'h8;
  localparam logic [3:0] FS_COMM = 4'h9;
  // Upper limit source codes
  localparam logic [2:0] UL_DIGITAL = 3'h0;
  localparam logic [2:0] UL_AI1 = 3'h1;
  localparam logic [2:0] UL_AI2 = 3'h2;
  localparam logic [2:0] UL_AI3 = 3'h3;
  localparam logic [2:0] UL_PULSE = 3'h4;
  localparam logic [2:0] UL_COMM = 3'h5;
  // Combination modes
  typedef enum logic [2:0] {
    AB_A = 3'h0, AB_B = 3'h1, AB_SWITCH = 3'h2, AB_SUM = 3'h3,
    AB_DIFF = 3'h4, AB_MAX = 3'h5, AB_MIN = 3'h6
  } dfrs_mode_e;
  // Carrier control states, Gray coded
  typedef enum logic [1:0] {
    CAR_NORMAL = 2'b00, CAR_REDUCED = 2'b01, CAR_RESTORE = 2'b11
  } dfrs_car_e;
  // Carrier adjustment pacing: one step per 1 ms
  localparam int CAR_STEP_US = 1000;
  localparam int CLK_MHZ = 20;
  localparam int CAR_STEP_CYCLES = CAR_STEP_US * CLK_MHZ;
  localparam int MODEL_CONST_TORQUE = 0;
endpackage

/* File: hw/dfrs_upper_limit.sv */
// Upper limit source selection with offset, registered output
`timescale 1ns/1ps
module dfrs_upper_limit import dfrs_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Selection and settings
  input wire logic [2:0] src_sel,
  input wire logic [15:0] digital_limit,
  input wire logic [15:0] offset,
  input wire logic [15:0] max_freq,
  // Candidate sources
  input wire logic [15:0] ai_one,
  input wire logic [15:0] ai_two,
  input wire logic [15:0] ai_three,
  input wire logic [15:0] pulse_in,
  input wire logic [15:0] comm_in,
  // Resolved limit
  output logic [15:0] limit
);
  logic [15:0] raw; // Selected source value
  logic [16:0] sum; // Source plus offset, one bit of headroom
  logic [15:0] limit_next;

  // Source mux, analog and pulse get the offset
  always_comb begin
    sum = {1'b0, 16'h0000};
    unique case (src_sel)
      UL_AI1: raw = ai_one;
      UL_AI2: raw = ai_two;
      UL_AI3: raw = ai_three;
      UL_PULSE: raw = pulse_in;
      UL_COMM: raw = comm_in;
      default: raw = digital_limit; // Codes 0 and illegal 6,7
    endcase
    if (src_sel inside {UL_AI1, UL_AI2, UL_AI3, UL_PULSE}) begin
      sum = {1'b0, raw} + {1'b0, offset};
    end else begin
      sum = {1'b0, raw};
    end
    // Never above maximum frequency
    if (sum > {1'b0, max_freq}) begin
      limit_next = max_freq;
    end else begin
      limit_next = sum[15:0];
    end
  end

  // Registered result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit <= 16'h0000;
    end else begin
      limit <= limit_next;
    end
  end
endmodule

/* File: hw/dfrs_top.sv */
// Frequency reference selection, carrier derating and parameter restore with APB registers
// Behaviour
// - Hot heatsink lowers carrier when enabled
// - Carrier returns to setting when cool
// - Upper limit source chosen by code
// - Analog/pulse limit adds limit offset
// - At limit, keep running at limit
// - UP/DOWN edits running or set frequency
// - Binding is one digit per command source, four digits in all
// - Bound source overrides A/B selection
// - Many commands may share one source
// - Aux B scaled zero to 150 percent
// - Sum/diff/max/min A/B result plus capped superposition offset
// - Retention 0 reloads preset on stop
// - Retention 1 keeps frequency on stop
// - Retention applies only for keypad source
// - Load model is read only
// - Restore: none, defaults, clear faults
// - Combination mode selects A/B operation
`timescale 1ns/1ps
module dfrs_top import dfrs_pkg::*; #(
  parameter int CAR_STEP_CNT = CAR_STEP_CYCLES // Cycles between carrier steps
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frequency sources, 0.01 Hz units
  input wire logic [15:0] freq_a,
  input wire logic [15:0] freq_b,
  input wire logic [15:0] analog_input_one,
  input wire logic [15:0] analog_input_two,
  input wire logic [15:0] analog_input_three,
  input wire logic [15:0] high_speed_pulse_input,
  input wire logic [15:0] comm_freq,
  input wire logic [15:0] multi_speed_freq,
  input wire logic [15:0] plc_freq,
  input wire logic [15:0] pid_freq,
  input wire logic [15:0] running_freq,
  // Command and terminal state
  input wire logic [1:0] cmd_source,
  input wire logic ab_switch_in,
  input wire logic running,
  input wire logic up_req,
  input wire logic down_req,
  input wire logic heatsink_hot,
  input wire logic model_strap,
  // Results
  output logic [15:0] target_freq,
  output logic [15:0] upper_limit,
  output logic at_limit,
  output logic [7:0] carrier_freq,
  output logic restore_defaults_pulse,
  output logic clear_fault_pulse
);
  // Software settings
  logic [31:0] ctrl_reg;
  logic [15:0] bind_reg;
  logic [15:0] ul_ofs_reg;
  logic [7:0] aux_range_reg;
  logic [15:0] sup_ofs_reg;
  logic [15:0] preset_reg;
  logic [15:0] maxf_reg;
  logic [15:0] ul_dig_reg;
  logic [7:0] carrier_set_reg;
  logic model_reg; // Captured once after reset
  logic model_taken_reg;
  // Block state
  logic [15:0] keypad_reg; // Keypad setting frequency
  logic running_reg; // For stop edge detection
  dfrs_car_e car_state_reg;
  logic [31:0] car_cnt_reg;
  // Decoded fields
  logic [2:0] mode;
  logic [2:0] ul_src;
  logic [3:0] fsrc; // Ordinary A source code
  logic carr_en;
  logic ud_base;
  logic retain;
  logic [3:0] bound; // Binding digit of active command source
  logic [15:0] ul_val;
  logic wr_en;
  logic rd_en;
  logic [15:0] target_next;
  logic [15:0] ab_result;
  logic [15:0] sel_freq;

  assign mode = ctrl_reg[CTRL_MODE_LSB +: 3];
  assign ul_src = ctrl_reg[CTRL_ULSRC_LSB +: 3];
  assign fsrc = ctrl_reg[CTRL_FSRC_LSB +: 4];
  assign carr_en = ctrl_reg[CTRL_CARR_EN_BIT];
  assign ud_base = ctrl_reg[CTRL_UDBASE_BIT];
  assign retain = ctrl_reg[CTRL_RETAIN_BIT];
  // Zero wait slave: access phase completes at once
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  // Each command source reads its own digit, so shared sources never collide
  assign bound = bind_reg[cmd_source*4 +: 4];

  // Upper limit resolver
  dfrs_upper_limit u_limit (
    .pclk(pclk),
    .presetn(presetn),
    .src_sel(ul_src),
    .digital_limit(ul_dig_reg),
    .offset(ul_ofs_reg),
    .max_freq(maxf_reg),
    .ai_one(analog_input_one),
    .ai_two(analog_input_two),
    .ai_three(analog_input_three),
    .pulse_in(high_speed_pulse_input),
    .comm_in(comm_freq),
    .limit(ul_val)
  );

  // Map a source code to its frequency
  function automatic logic [15:0] src_freq(input logic [3:0] code, input logic [15:0] kp);
    logic [15:0] f;
    f = 16'h0000;
    unique case (code)
      FS_KEYPAD: f = kp;
      FS_AI1: f = analog_input_one;
      FS_AI2: f = analog_input_two;
      FS_AI3: f = analog_input_three;
      FS_PULSE: f = high_speed_pulse_input;
      FS_MULTI: f = multi_speed_freq;
      FS_PLC: f = plc_freq;
      FS_PID: f = pid_freq;
      FS_COMM: f = comm_freq;
      default: f = 16'h0000;
    endcase
    return f;
  endfunction

  // A/B combination, offset, binding, clamp
  always_comb begin
    logic [23:0] b_scaled;
    logic [15:0] b_eff;
    logic [15:0] a_eff;
    logic [16:0] tmp;
    logic [15:0] sofs;
    b_scaled = freq_b * aux_range_reg;
    b_eff = 16'((b_scaled / 24'd100));
    a_eff = (fsrc == FS_NONE) ? freq_a : src_freq(fsrc, keypad_reg);
    sofs = (sup_ofs_reg > maxf_reg) ? maxf_reg : sup_ofs_reg;
    tmp = {1'b0, a_eff};
    unique case (dfrs_mode_e'(mode))
      AB_A: tmp = {1'b0, a_eff};
      AB_B: tmp = {1'b0, b_eff};
      AB_SWITCH: tmp = ab_switch_in ? {1'b0, b_eff} : {1'b0, a_eff};
      AB_SUM: tmp = {1'b0, a_eff} + {1'b0, b_eff} + {1'b0, sofs};
      AB_DIFF: tmp = (a_eff > b_eff) ? {1'b0, a_eff - b_eff} + {1'b0, sofs} : {1'b0, sofs};
      AB_MAX: tmp = ((a_eff > b_eff) ? {1'b0, a_eff} : {1'b0, b_eff}) + {1'b0, sofs};
      AB_MIN: tmp = ((a_eff < b_eff) ? {1'b0, a_eff} : {1'b0, b_eff}) + {1'b0, sofs};
      default: tmp = {1'b0, a_eff}; // Illegal mode falls back to A
    endcase
    ab_result = (tmp > {1'b0, maxf_reg}) ? maxf_reg : tmp[15:0];
    // Binding wins over the A/B settings
    sel_freq = (bound != FS_NONE) ? src_freq(bound, keypad_reg) : ab_result;
    // Clamp: run at limit instead of exceeding it
    target_next = (sel_freq > ul_val) ? ul_val : sel_freq;
  end

  // APB register writes and restore command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      bind_reg <= BIND_RESET;
      ul_ofs_reg <= OFS_RESET;
      aux_range_reg <= AUX_RANGE_RESET;
      sup_ofs_reg <= OFS_RESET;
      preset_reg <= PRESET_RESET;
      maxf_reg <= MAXF_RESET;
      ul_dig_reg <= UL_DIG_RESET;
      carrier_set_reg <= CARRIER_RESET;
      restore_defaults_pulse <= 1'b0;
      clear_fault_pulse <= 1'b0;
    end else begin
      restore_defaults_pulse <= 1'b0;
      clear_fault_pulse <= 1'b0;
      if (wr_en) begin
        unique case (paddr)
          OFF_CTRL: ctrl_reg <= pwdata & 32'h0000_7777;
          OFF_BIND: bind_reg <= pwdata[15:0];
          OFF_UL_OFS: ul_ofs_reg <= pwdata[15:0];
          OFF_AUX_RANGE: begin
            // Values above 150 percent are saturated
            aux_range_reg <= (pwdata[7:0] > AUX_RANGE_MAX) ? AUX_RANGE_MAX : pwdata[7:0];
          end
          OFF_SUP_OFS: sup_ofs_reg <= pwdata[15:0];
          OFF_PRESET: preset_reg <= pwdata[15:0];
          OFF_MAXF: maxf_reg <= pwdata[15:0];
          OFF_UL_DIG: ul_dig_reg <= pwdata[15:0];
          OFF_CARRIER: carrier_set_reg <= pwdata[7:0];
          OFF_RESTORE: begin
            // One pulse per defaults or fault-clear write, none for other codes, register never stores the code
            if (pwdata[1:0] == RESTORE_DEFAULTS) begin
              ctrl_reg <= CTRL_RESET;
              bind_reg <= BIND_RESET;
              ul_ofs_reg <= OFS_RESET;
              aux_range_reg <= AUX_RANGE_RESET;
              sup_ofs_reg <= OFS_RESET;
              preset_reg <= PRESET_RESET;
              ul_dig_reg <= UL_DIG_RESET;
              restore_defaults_pulse <= 1'b1;
            end else if (pwdata[1:0] == RESTORE_CLR_FAULT) begin
              clear_fault_pulse <= 1'b1;
            end
          end
          default: ; // Model is read only, others ignored
        endcase
      end
    end
  end

  // Model strap captured after reset release, never written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      model_reg <= 1'b0;
      model_taken_reg <= 1'b0;
    end else if (!model_taken_reg) begin
      model_reg <= model_strap;
      model_taken_reg <= 1'b1;
    end
  end

  // Keypad setting frequency: UP/DOWN and stop behaviour
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keypad_reg <= PRESET_RESET;
      running_reg <= 1'b0;
    end else begin
      running_reg <= running;
      if (fsrc == FS_KEYPAD && running_reg && !running) begin
        // Stop edge: retention only matters on keypad source
        if (!retain) begin
          keypad_reg <= preset_reg;
        end // Retention 1 keeps the value
      end else if (fsrc == FS_KEYPAD && (up_req ^ down_req)) begin
        // Base is running frequency (0) or set frequency (1)
        if (up_req) begin
          keypad_reg <= ((ud_base ? keypad_reg : running_freq) >= maxf_reg) ? maxf_reg :
                        (ud_base ? keypad_reg : running_freq) + UPDOWN_STEP;
        end else begin
          keypad_reg <= ((ud_base ? keypad_reg : running_freq) == 16'h0000) ? 16'h0000 :
                        (ud_base ? keypad_reg : running_freq) - UPDOWN_STEP;
        end
      end else if (wr_en && paddr == OFF_PRESET && !running) begin
        keypad_reg <= pwdata[15:0];
      end
    end
  end

  // Carrier derating state machine, one step per pacing period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      car_state_reg <= CAR_NORMAL;
      car_cnt_reg <= 32'h0000_0000;
      carrier_freq <= CARRIER_RESET;
    end else begin
      // Pacing keeps the carrier from slamming between values
      if (car_cnt_reg >= 32'(CAR_STEP_CNT - 1)) begin
        car_cnt_reg <= 32'h0000_0000;
      end else begin
        car_cnt_reg <= car_cnt_reg + 32'h0000_0001;
      end
      unique case (car_state_reg)
        CAR_NORMAL: begin
          carrier_freq <= carrier_set_reg;
          if (carr_en && heatsink_hot) begin
            car_state_reg <= CAR_REDUCED;
          end
        end
        CAR_REDUCED: begin
          if (!carr_en || !heatsink_hot) begin
            car_state_reg <= CAR_RESTORE;
          end else if (car_cnt_reg == 32'h0000_0000 &&
                       carrier_freq >= CARRIER_MIN + CARRIER_STEP) begin
            carrier_freq <= carrier_freq - CARRIER_STEP;
          end
        end
        CAR_RESTORE: begin
          carrier_freq <= carrier_set_reg;
          car_state_reg <= CAR_NORMAL;
        end
        default: car_state_reg <= CAR_NORMAL;
      endcase
    end
  end

  // Target, limit and status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_freq <= 16'h0000;
      upper_limit <= 16'h0000;
      at_limit <= 1'b0;
    end else begin
      target_freq <= target_next;
      upper_limit <= ul_val;
      at_limit <= (sel_freq >= ul_val);
    end
  end

  // APB read data and response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          OFF_CTRL: prdata <= ctrl_reg;
          OFF_BIND: prdata <= {16'h0000, bind_reg};
          OFF_UL_OFS: prdata <= {16'h0000, ul_ofs_reg};
          OFF_AUX_RANGE: prdata <= {24'h000000, aux_range_reg};
          OFF_SUP_OFS: prdata <= {16'h0000, sup_ofs_reg};
          OFF_PRESET: prdata <= {16'h0000, preset_reg};
          OFF_MAXF: prdata <= {16'h0000, maxf_reg};
          OFF_UL_DIG: prdata <= {16'h0000, ul_dig_reg};
          OFF_CARRIER: prdata <= {24'h000000, carrier_set_reg};
          OFF_MODEL: prdata <= {31'h0000_0000, model_reg};
          OFF_RESTORE: prdata <= 32'h0000_0000;
          OFF_STATUS: prdata <= {22'h000000, car_state_reg, carrier_freq};
          OFF_TARGET: prdata <= {15'h0000, at_limit, target_freq};
          OFF_KEYPAD: prdata <= {16'h0000, keypad_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
      if (psel && !penable && paddr > OFF_KEYPAD) begin
        pslverr <= 1'b1; // Unmapped address
      end
    end
  end
endmodule

/* File: sim/dfrs_top_asserts.sv */
// Port-level checker for the frequency reference selector
`timescale 1ns/1ps
module dfrs_top_asserts import dfrs_pkg::*; #(
  parameter int CAR_STEP_CNT = CAR_STEP_CYCLES // Kept equal to the design's pacing
) (
  // APB side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Results and heat input
  input wire logic heatsink_hot,
  input wire logic [15:0] target_freq,
  input wire logic [15:0] upper_limit,
  input wire logic at_limit,
  input wire logic [7:0] carrier_freq,
  input wire logic restore_defaults_pulse,
  input wire logic clear_fault_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write strobes of the two restore commands
  wire logic wr_def = psel && penable && pwrite && paddr == OFF_RESTORE && pwdata[1:0] == 2'h1;
  wire logic wr_clr = psel && penable && pwrite && paddr == OFF_RESTORE && pwdata[1:0] == 2'h2;
  // Limit unchanged long enough for the target stage to have seen it
  sequence ul_steady;
    $stable(upper_limit) [*2];
  endsequence
  // Heatsink cool for a few cycles
  sequence cool_run;
    !heatsink_hot [*4];
  endsequence
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_slverr_range: assert property (pready |-> pslverr == (paddr > OFF_KEYPAD))
    else $error("error response wrong");
  chk_target_clamped: assert property (ul_steady |-> target_freq <= upper_limit)
    else $error("target above limit");
  chk_limit_hold: assert property (ul_steady ##0 at_limit |-> target_freq == upper_limit)
    else $error("limit flag without limit");
  chk_defaults_cause: assert property ($rose(restore_defaults_pulse) |-> $past(wr_def) || $past(wr_def, 2))
    else $error("defaults pulse without command");
  chk_fault_cause: assert property ($rose(clear_fault_pulse) |-> $past(wr_clr) || $past(wr_clr, 2))
    else $error("fault clear without command");
  chk_pulse_once: assert property (restore_defaults_pulse || clear_fault_pulse |=> !restore_defaults_pulse && !clear_fault_pulse)
    else $error("restore pulse too long");
  chk_restore_zero: assert property (pready && !pwrite && paddr == OFF_RESTORE |-> prdata == 32'h0)
    else $error("restore selector not zero");
  chk_model_ro: assert property (pready && !pwrite && paddr == OFF_MODEL |-> prdata[31:1] == 31'h0)
    else $error("model field too wide");
  chk_carrier_step: assert property (carrier_freq < $past(carrier_freq) |-> $past(heatsink_hot) && $past(carrier_freq) - carrier_freq <= CARRIER_STEP)
    else $error("carrier drop wrong");
  chk_carrier_cool: assert property (cool_run |-> $stable(carrier_freq))
    else $error("carrier moving while cool");
endmodule
bind dfrs_top dfrs_top_asserts #(.CAR_STEP_CNT(CAR_STEP_CNT)) i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .heatsink_hot(heatsink_hot),
  .target_freq(target_freq), .upper_limit(upper_limit), .at_limit(at_limit),
  .carrier_freq(carrier_freq), .restore_defaults_pulse(restore_defaults_pulse),
  .clear_fault_pulse(clear_fault_pulse));

/* File: sim/dfrs_terminal_model.sv */
// Terminal side model: run command and UP/DOWN keys
`timescale 1ns/1ps
module dfrs_terminal_model (
  // Clock
  input wire logic pclk,
  // Terminal lines
  output logic running,
  output logic up_req,
  output logic down_req
);
  // Stopped, no key held at power-up
  initial begin
    running = 1'b0;
    up_req = 1'b0;
    down_req = 1'b0;
  end
  // Hold one key for n edges, each high cycle is one step
  task automatic press(input logic up, input int n);
    up_req <= up;
    down_req <= !up;
    repeat (n) @(posedge pclk);
    up_req <= 1'b0;
    down_req <= 1'b0;
    @(posedge pclk);
  endtask
  // Start or stop; stop is seen a cycle late, so allow settling
  task automatic run(input logic on);
    running <= on;
    repeat (3) @(posedge pclk);
  endtask
endmodule

/* File: sim/dfrs_top_test.sv */
// Self-checking bench for the frequency reference selector
`timescale 1ns/1ps
module dfrs_top_test import dfrs_pkg::*;;
  // Bus, sources and status
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, se, ab_sw = 1'b0, hot = 1'b0, at_limit, rdp, cfp;
  logic [1:0] cmd = 2'h0;
  logic [15:0] fa = 16'h0, fb = 16'h0, tgt, ul, rf = 16'h0;
  logic [15:0] fs [2:9];
  logic [7:0] car;
  logic running, up_req, down_req;
  int n_mismatch = 0, n_checks = 0, seed = 59535, n_rd = 0, n_cf = 0;
  // Reset table: address and value
  logic [7:0] ra [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28};
  logic [31:0] rv [11] = '{32'h1000, 32'h0, 32'h0, 32'h64, 32'h0, 32'h1388, 32'h1388, 32'h1388,
    32'h3C, 32'h1, 32'h0};
  always #25 pclk = ~pclk;
  // Pulse counters
  always @(posedge pclk) begin
    n_rd += rdp;
    n_cf += cfp;
  end
  dfrs_top #(.CAR_STEP_CNT(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .freq_a(fa), .freq_b(fb), .analog_input_one(fs[2]),
    .analog_input_two(fs[3]), .analog_input_three(fs[4]), .high_speed_pulse_input(fs[5]),
    .comm_freq(fs[9]), .multi_speed_freq(fs[6]), .plc_freq(fs[7]), .pid_freq(fs[8]),
    .running_freq(rf), .cmd_source(cmd), .ab_switch_in(ab_sw), .running(running),
    .up_req(up_req), .down_req(down_req), .heatsink_hot(hot), .model_strap(1'b1),
    .target_freq(tgt), .upper_limit(ul), .at_limit(at_limit), .carrier_freq(car),
    .restore_defaults_pulse(rdp), .clear_fault_pulse(cfp));
  dfrs_terminal_model i_term (.pclk(pclk), .running(running), .up_req(up_req),
    .down_req(down_req));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for ready; only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction
  // Reference combination, offset only for the arithmetic modes
  function automatic int exp_tgt(int m, int a, int b, int ofs, int lim, logic sw);
    int r;
    case (m)
      0: r = a;
      1: r = b;
      2: r = sw ? b : a;
      3: r = a + b;
      4: r = (a > b) ? a - b : 0;
      5: r = (a > b) ? a : b;
      default: r = (a < b) ? a : b;
    endcase
    if (m > 2) r += ofs;
    return (r > lim) ? lim : r;
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog well past the expected few hundred cycles
  initial begin
    #1000000;
    n_mismatch++;
    summarize();
  end
  initial begin
    int e, ofs, a0, c0, kp;
    int dg [4];
    foreach (fs[i]) fs[i] = 16'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, unmapped read, read-only model
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(q, rv[i]);
    end
    apb(1'b0, 8'h38, 32'h0);
    chk(se, 32'h1);
    apb(1'b1, OFF_MODEL, 32'h0);
    apb(1'b0, OFF_MODEL, 32'h0);
    chk(q, 32'h1);
    // Every combination mode with random operands and offset
    for (int i = 0; i < 28; i++) begin
      ofs = rnd(500);
      ab_sw <= 1'(rnd(2));
      fa <= 16'(rnd(3000));
      fb <= 16'(rnd(3000));
      apb(1'b1, OFF_SUP_OFS, ofs);
      apb(1'b1, OFF_CTRL, 32'h1000 | (i % 7));
      wt(3);
      e = exp_tgt(i % 7, fa, fb, ofs, 5000, ab_sw);
      chk(tgt, e);
      chk(at_limit, e == 5000);
    end
    // Auxiliary range saturates and scales B
    apb(1'b1, OFF_AUX_RANGE, 32'hC8);
    apb(1'b0, OFF_AUX_RANGE, 32'h0);
    chk(q, 32'h96);
    fa <= 16'd200;
    fb <= 16'd1000;
    apb(1'b1, OFF_SUP_OFS, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h1003);
    wt(3);
    chk(tgt, 32'd1700);
    apb(1'b1, OFF_AUX_RANGE, 32'h64);
    // Upper limit from each source code
    apb(1'b1, OFF_UL_OFS, 32'd300);
    for (int c = 0; c < 6; c++) begin
      foreach (fs[k]) fs[k] <= 16'(1000 + rnd(4500));
      fa <= 16'(rnd(5000)); // A may exceed the limit
      apb(1'b1, OFF_CTRL, 32'h1000 | (c << 4));
      wt(3);
      e = (c == 0) ? 5000 : (c == 5) ? fs[9] : fs[c + 1] + 300;
      e = (e > 5000) ? 5000 : e;
      chk(ul, e);
      chk(tgt, (fa > e) ? e : fa);
    end
    // Bindings per command source; sum mode and offset must be ignored
    kp = 5000;
    apb(1'b1, OFF_SUP_OFS, 32'd400);
    apb(1'b1, OFF_CTRL, 32'h1003);
    for (int j = 0; j < 3; j++) begin
      foreach (dg[d]) dg[d] = (j == 0) ? 5 : 1 + rnd(9);
      apb(1'b1, OFF_BIND, dg[0] + dg[1] * 16 + dg[2] * 256 + dg[3] * 4096);
      for (int s = 0; s < 4; s++) begin
        cmd <= 2'(s);
        wt(3);
        e = (dg[s] == 1) ? kp : fs[dg[s]];
        chk(tgt, (e > 5000) ? 5000 : e);
      end
    end
    apb(1'b1, OFF_BIND, 32'h0);
    cmd <= 2'h0;
    // UP/DOWN on the set frequency, stop without then with retention
    kp = 1000;
    apb(1'b1, OFF_PRESET, kp);
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, OFF_CTRL, 32'h3100 | (r << 14));
      i_term.run(1'b1);
      i_term.press(1'b1, 5);
      i_term.press(1'b0, 2);
      apb(1'b0, OFF_KEYPAD, 32'h0);
      chk(q, kp + 3);
      i_term.run(1'b0);
      if (r == 1) kp = kp + 3;
      apb(1'b0, OFF_KEYPAD, 32'h0);
      chk(q, kp);
    end
    // Other source: keys and stop leave the keypad value alone
    apb(1'b1, OFF_CTRL, 32'h3200);
    i_term.run(1'b1);
    i_term.press(1'b1, 4);
    i_term.run(1'b0);
    apb(1'b0, OFF_KEYPAD, 32'h0);
    chk(q, kp);
    // Base 0: each key step starts from the running frequency
    rf <= 16'(rnd(4000));
    apb(1'b1, OFF_CTRL, 32'h1100);
    i_term.press(1'b1, 2);
    apb(1'b0, OFF_KEYPAD, 32'h0);
    chk(q, rf + 1);
    // Hot heatsink derates to the floor, cool restores; disabled holds
    apb(1'b1, OFF_CTRL, 32'h1000);
    hot <= 1'b1;
    wt(80);
    chk(car, CARRIER_MIN + (CARRIER_RESET - CARRIER_MIN) % CARRIER_STEP);
    hot <= 1'b0;
    wt(4);
    chk(car, CARRIER_RESET);
    apb(1'b1, OFF_CTRL, 32'h0);
    hot <= 1'b1;
    wt(30);
    chk(car, CARRIER_RESET);
    hot <= 1'b0;
    // Restore commands: none, defaults, fault clear
    for (int v = 0; v < 3; v++) begin
      a0 = n_rd;
      c0 = n_cf;
      apb(1'b1, OFF_RESTORE, v);
      wt(4);
      chk(n_rd - a0, v == 1);
      chk(n_cf - c0, v == 2);
    end
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(q, 32'h1000);
    summarize();
  end
endmodule
